// *** ata_wr_map.svh ***
// Task-file map, opcodes, feature codes, field positions and reset values
// How it works
// (R1) Opcodes 30h/31h differ in bit 0; bit 0 set disables media retries.
// (R2) A loaded sector count of zero means 256 sectors.
// (R3) Write payload enters through the data register as 16-bit words.
// (R4) An uncorrectable media error ends the command at the failing sector.
// (R5) Address mode bit selects LBA split over four registers, else CHS.
// (R6) At the end the count register holds sectors not written.
// (R7) At the end the address registers hold the last sector written, or the failing sector on a media failure.
// (R8) With write cache on, the retry bit is ignored.
// (R9) Mandatory opcodes, queued DMA and security F1h-F6h are accepted.
// (R10) Write-verify runs exactly as a sector write, with no read-back.
// (R11) Feature 05h enables and 85h disables advanced power management.
// (R12) Feature 42h enables and C2h disables acoustic management.
// (R13) Feature 44h selects long vendor ECC, BBh selects 4-byte ECC.
// (R14) Feature 55h disables read look-ahead, AAh re-enables it.
// (R15) Feature 66h disables reverting to defaults, CCh re-enables it.
// (R16) Features 06h/86h set/clear power-up in standby; 07h spins up.
// (R17) Feature 09h enables and 89h disables address offset mode.
// (R18) Unsupported opcode or feature ends with abort flag and error status.
// (R19) On completion busy clears; error register shows only ID_NOT_FOUND_FLAG and ABORTED_COMMAND_FLAG.
`ifndef ATA_WR_MAP_SVH
`define ATA_WR_MAP_SVH
`define TF_DATA          3'h0
`define TF_FEAT          3'h1
`define TF_COUNT         3'h2
`define TF_SECT          3'h3
`define TF_CYLLO         3'h4
`define TF_CYLHI         3'h5
`define TF_DEVHD         3'h6
`define TF_CMD           3'h7
`define OP_WRITE_RETRY   8'h30
`define OP_WRITE_NORETRY 8'h31
`define OP_WRITE_VERIFY  8'h3c
`define OP_WRITE_MULTI   8'hc5
`define OP_SET_FEATURES  8'hef
`define FT_WCACHE_ON     8'h02
`define FT_XFER_MODE     8'h03
`define FT_APM_ON        8'h05
`define FT_PUIS_ON       8'h06
`define FT_SPIN_UP       8'h07
`define FT_OFFSET_ON     8'h09
`define FT_AAM_ON        8'h42
`define FT_ECC_LONG      8'h44
`define FT_LOOK_OFF      8'h55
`define FT_REL_ON        8'h5d
`define FT_REVERT_OFF    8'h66
`define FT_WCACHE_OFF    8'h82
`define FT_APM_OFF       8'h85
`define FT_PUIS_OFF      8'h86
`define FT_OFFSET_OFF    8'h89
`define FT_LOOK_ON       8'haa
`define FT_ECC_4         8'hbb
`define FT_AAM_OFF       8'hc2
`define FT_REVERT_ON     8'hcc
`define FT_REL_OFF       8'hdd
`define FL_APM           0
`define FL_AAM           1
`define FL_ECC_LONG      2
`define FL_NO_LOOK       3
`define FL_NO_REVERT     4
`define FL_PUIS          5
`define FL_OFFSET        6
`define FL_WCACHE        7
`define FLAGS_RST        8'h00
`define ST_BSY           7
`define ST_RDY           6
`define ST_DSC           4
`define ST_DRQ           3
`define ST_ERR           0
`define ERR_IDN          4
`define ERR_ABT          2
`define DH_LBA           6
`define DH_HEAD          3:0
`define SECT_PER_TRACK   8'h3f
`define SECT_FIRST       8'h01
`define HEAD_LAST        4'hf
`define COUNT_ZERO_SECTS 9'h100
`define TF_RST           8'h00
`endif

// *** ata_wr_pkg.sv ***
// Types shared by the sector-write command decoder
package ata_wr_pkg;
  typedef enum logic [1:0] {CMD_WRITE, CMD_FEATURE, CMD_OTHER, CMD_REJECT} cmd_class_e;
  typedef enum logic {ST_IDLE, ST_XFER} state_e;
  typedef logic [7:0] byte_t;
endpackage : ata_wr_pkg

// *** ata_wr_fifo.sv ***
// Word FIFO between host data register and media write path
`timescale 1ns/1ns
module ata_wr_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             flush,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  // Depth must be a power of two so pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      level_r;
  logic             push;
  logic             pop;

  assign inReady  = level_r != (AW+1)'(DEPTH);
  assign outValid = level_r != '0;
  assign outData  = mem[rdPtr_r];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wrPtr_r] <= inData;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || flush)
    begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      level_r <= '0;
    end
    else
    begin
      if (push)
        wrPtr_r <= wrPtr_r + 1'b1;
      if (pop)
        rdPtr_r <= rdPtr_r + 1'b1;
      if (push && !pop)
        level_r <= level_r + 1'b1;
      else if (pop && !push)
        level_r <= level_r - 1'b1;
    end
  end
endmodule : ata_wr_fifo

// *** ata_cmd_classify.sv ***
// Opcode acceptance and feature subcommand decode
`timescale 1ns/1ns
`include "ata_wr_map.svh"
module ata_cmd_classify (
  input  wire ata_wr_pkg::byte_t      opcode,
  input  wire ata_wr_pkg::byte_t      featCode,
  output ata_wr_pkg::cmd_class_e      cmdClass,
  output logic                        featOk,
  output ata_wr_pkg::byte_t           featSet,
  output ata_wr_pkg::byte_t           featClr,
  output logic                        featSpin
);
  import ata_wr_pkg::*;

  function automatic byte_t bitOf(input int pos);
    bitOf = byte_t'(1) << pos;
  endfunction : bitOf

  always_comb
  begin
    cmdClass = CMD_REJECT;
    unique casez (opcode)
      `OP_WRITE_RETRY, `OP_WRITE_NORETRY, `OP_WRITE_MULTI,
      `OP_WRITE_VERIFY:                                          // [R10]
        cmdClass = CMD_WRITE;
      `OP_SET_FEATURES:
        cmdClass = CMD_FEATURE;
      8'h00, 8'h1?, 8'h20, 8'h21, 8'h22, 8'h23, 8'h32, 8'h33,
      8'h40, 8'h41, 8'h50, 8'h7?, 8'h90, 8'h91, 8'ha2, 8'hb0,
      8'hc4, 8'hc6, 8'hc7, 8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc,
      8'he0, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5, 8'he6, 8'he7,
      8'he8, 8'hec, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
      8'hf6, 8'hf7, 8'hf8, 8'hf9:                                // [R9]
        cmdClass = CMD_OTHER;
      default:
        cmdClass = CMD_REJECT;                                   // [R18]
    endcase
  end

  always_comb
  begin
    featOk   = 1'b1;
    featSet  = '0;
    featClr  = '0;
    featSpin = 1'b0;
    unique case (featCode)
      `FT_WCACHE_ON:  featSet = bitOf(`FL_WCACHE);
      `FT_WCACHE_OFF: featClr = bitOf(`FL_WCACHE);
      `FT_APM_ON:     featSet = bitOf(`FL_APM);         // [R11]
      `FT_APM_OFF:    featClr = bitOf(`FL_APM);         // [R11]
      `FT_AAM_ON:     featSet = bitOf(`FL_AAM);         // [R12]
      `FT_AAM_OFF:    featClr = bitOf(`FL_AAM);         // [R12]
      `FT_ECC_LONG:   featSet = bitOf(`FL_ECC_LONG);    // [R13]
      `FT_ECC_4:      featClr = bitOf(`FL_ECC_LONG);    // [R13]
      `FT_LOOK_OFF:   featSet = bitOf(`FL_NO_LOOK);     // [R14]
      `FT_LOOK_ON:    featClr = bitOf(`FL_NO_LOOK);     // [R14]
      `FT_REVERT_OFF: featSet = bitOf(`FL_NO_REVERT);   // [R15]
      `FT_REVERT_ON:  featClr = bitOf(`FL_NO_REVERT);   // [R15]
      `FT_PUIS_ON:    featSet = bitOf(`FL_PUIS);        // [R16]
      `FT_PUIS_OFF:   featClr = bitOf(`FL_PUIS);        // [R16]
      `FT_SPIN_UP:    featSpin = 1'b1;                  // [R16]
      `FT_OFFSET_ON:  featSet = bitOf(`FL_OFFSET);      // [R17]
      `FT_OFFSET_OFF: featClr = bitOf(`FL_OFFSET);      // [R17]
      `FT_XFER_MODE, `FT_REL_ON, `FT_REL_OFF:
        featOk = 1'b1;
      default:
        featOk = 1'b0;                                  // [R18]
    endcase
  end
endmodule : ata_cmd_classify

// *** ata_sector_write_cmd_decode.sv ***
// Drive-side task file and sector-write command engine
`timescale 1ns/1ns
`include "ata_wr_map.svh"
module ata_sector_write_cmd_decode (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               hostWrEn,
  input  wire logic [2:0]         hostAddr,
  input  wire logic [15:0]        hostWrData,
  output logic      [15:0]        hostRdData,
  output logic                    hostDrq,
  output logic                    hostWrReady,
  output logic                    mediaValid,
  input  wire logic               mediaReady,
  output logic      [15:0]        mediaData,
  input  wire logic               mediaSectorDone,
  input  wire logic               mediaUncErr,
  input  wire logic               mediaIdnf,
  output logic                    retryDisable,
  output ata_wr_pkg::byte_t       featureFlags,
  output logic                    spinUpReq,
  output logic                    otherCmdValid,
  output ata_wr_pkg::byte_t       otherCmdCode
);
  import ata_wr_pkg::*;

  state_e     state_r;
  byte_t      feat_r;
  byte_t      count_r;
  byte_t      sec_r;
  byte_t      cylLo_r;
  byte_t      cylHi_r;
  byte_t      devHead_r;
  byte_t      errFlags_r;
  byte_t      flags_r;
  byte_t      status;
  logic [8:0] sectorsLeft_r;
  logic [8:0] sectorsStart;
  logic [16:0] wordsLeft_r;
  logic       retryDisable_r;
  logic       spinUp_r;
  logic       otherCmd_r;
  byte_t      otherCode_r;
  logic [15:0] rdData_r;
  cmd_class_e cmdClass;
  logic       featOk;
  byte_t      featSet;
  byte_t      featClr;
  logic       featSpin;
  logic       cmdWr;
  logic       tfWr;
  logic       startWrite;
  logic       startFeat;
  logic       drq;
  logic       busy;
  logic       push;
  logic       fifoInReady;
  logic       xfer;
  logic       failEvt;
  logic       sectEvt;
  logic       lastSect;
  logic       lbaMode;
  logic [27:0] curAddr;
  logic [27:0] nextAddr;

  // Next sector address; LBA is a plain 28-bit count, CHS walks the geometry
  function automatic logic [27:0] advance(input logic lba, input logic [27:0] a);
    logic [27:0] r;
    r = a;
    if (lba)
      r = a + 28'h000_0001;
    else if (a[7:0] != `SECT_PER_TRACK)
      r[7:0] = a[7:0] + 8'h01;
    else
    begin
      r[7:0] = `SECT_FIRST;
      if (a[27:24] != `HEAD_LAST)
        r[27:24] = a[27:24] + 4'h1;
      else
      begin
        r[27:24] = 4'h0;
        r[23:8]  = a[23:8] + 16'h0001;
      end
    end
    advance = r;
  endfunction : advance

  ata_cmd_classify u_classify (
    .opcode   (hostWrData[7:0]),
    .featCode (feat_r),
    .cmdClass (cmdClass),
    .featOk   (featOk),
    .featSet  (featSet),
    .featClr  (featClr),
    .featSpin (featSpin)
  );

  // Host writes to the data register only land while the buffer has room
  ata_wr_fifo #(
    .WIDTH (16),
    .DEPTH (16)
  ) u_fifo (
    .core_clk (core_clk),
    .reset    (reset),
    .flush    (failEvt),
    .inValid  (push),
    .inReady  (fifoInReady),
    .inData   (hostWrData),
    .outValid (mediaValid),
    .outReady (mediaReady),
    .outData  (mediaData)
  );

  assign xfer       = state_r == ST_XFER;
  assign tfWr       = hostWrEn && state_r == ST_IDLE;
  assign cmdWr      = tfWr && hostAddr == `TF_CMD;
  assign startWrite = cmdWr && cmdClass == CMD_WRITE;
  assign startFeat  = cmdWr && cmdClass == CMD_FEATURE;
  assign drq        = xfer && wordsLeft_r != '0;
  assign push       = hostWrEn && hostAddr == `TF_DATA && drq && fifoInReady; // [R3]
  assign busy       = xfer && !drq;
  assign hostDrq    = drq;
  assign hostWrReady = drq && fifoInReady;
  assign failEvt    = xfer && (mediaUncErr || mediaIdnf);
  assign sectEvt    = xfer && mediaSectorDone && !failEvt;
  assign lastSect   = sectorsLeft_r == 9'h001;
  assign lbaMode    = devHead_r[`DH_LBA];
  assign curAddr    = {devHead_r[`DH_HEAD], cylHi_r, cylLo_r, sec_r};  // [R5]
  assign nextAddr   = advance(lbaMode, curAddr);                        // [R5]
  assign sectorsStart = (count_r == `TF_RST) ? `COUNT_ZERO_SECTS
                                             : {1'b0, count_r};       // [R2]

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (startWrite)
            state_r <= ST_XFER;
        ST_XFER:
          if (failEvt || (sectEvt && lastSect))
            state_r <= ST_IDLE;                         // [R4] [R19]
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      sectorsLeft_r <= '0;
    else if (startWrite)
      sectorsLeft_r <= sectorsStart;                    // [R2]
    else if (sectEvt)
      sectorsLeft_r <= sectorsLeft_r - 9'h001;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      wordsLeft_r <= '0;
    else if (startWrite)
      wordsLeft_r <= {sectorsStart, 8'h00};
    else if (failEvt)
      wordsLeft_r <= '0;                                // [R4]
    else if (push)
      wordsLeft_r <= wordsLeft_r - 17'h0_0001;
  end

  // Address registers stop on the last sector written, or on the failing one
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      sec_r     <= `TF_RST;
      cylLo_r   <= `TF_RST;
      cylHi_r   <= `TF_RST;
      devHead_r <= `TF_RST;
      feat_r    <= `TF_RST;
    end
    else if (tfWr)
    begin
      unique case (hostAddr)
        `TF_FEAT:  feat_r    <= hostWrData[7:0];
        `TF_SECT:  sec_r     <= hostWrData[7:0];
        `TF_CYLLO: cylLo_r   <= hostWrData[7:0];
        `TF_CYLHI: cylHi_r   <= hostWrData[7:0];
        `TF_DEVHD: devHead_r <= hostWrData[7:0];
        default:   feat_r    <= feat_r;
      endcase
    end
    else if (sectEvt && !lastSect)
    begin
      sec_r                 <= nextAddr[7:0];           // [R7]
      cylLo_r               <= nextAddr[15:8];
      cylHi_r               <= nextAddr[23:16];
      devHead_r[`DH_HEAD]   <= nextAddr[27:24];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      count_r <= `TF_RST;
    else if (tfWr && hostAddr == `TF_COUNT)
      count_r <= hostWrData[7:0];
    else if (failEvt)
      count_r <= sectorsLeft_r[7:0];                    // [R6]
    else if (sectEvt && lastSect)
      count_r <= `TF_RST;                               // [R6]
  end

  // New command clears flags and sets abort if rejected; media failures set flags during a transfer
  always_ff @(posedge core_clk)
  begin
    if (reset)
      errFlags_r <= `TF_RST;
    else if (cmdWr)
    begin
      errFlags_r <= `TF_RST;
      if (cmdClass == CMD_REJECT || (cmdClass == CMD_FEATURE && !featOk))
        errFlags_r[`ERR_ABT] <= 1'b1;                   // [R18]
    end
    else if (failEvt)
    begin
      errFlags_r[`ERR_ABT] <= mediaUncErr;              // [R19]
      errFlags_r[`ERR_IDN] <= mediaIdnf;                // [R19]
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      flags_r <= `FLAGS_RST;
    else if (startFeat && featOk)
      flags_r <= (flags_r | featSet) & ~featClr;        // [R11] [R12] [R13] [R14] [R15] [R16] [R17]
  end

  // Cache on means the retry bit is ignored
  always_ff @(posedge core_clk)
  begin
    if (reset)
      retryDisable_r <= 1'b0;
    else if (startWrite)
      retryDisable_r <= hostWrData[7:0] == `OP_WRITE_NORETRY
                        && !flags_r[`FL_WCACHE];        // [R1] [R8]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      spinUp_r    <= 1'b0;
      otherCmd_r  <= 1'b0;
      otherCode_r <= `TF_RST;
    end
    else
    begin
      spinUp_r   <= startFeat && featOk && featSpin;    // [R16]
      otherCmd_r <= cmdWr && cmdClass == CMD_OTHER;     // [R9]
      if (cmdWr && cmdClass == CMD_OTHER)
        otherCode_r <= hostWrData[7:0];
    end
  end

  always_comb
  begin
    status          = '0;
    status[`ST_BSY] = busy;                             // [R19]
    status[`ST_RDY] = 1'b1;
    status[`ST_DSC] = 1'b1;
    status[`ST_DRQ] = drq;
    status[`ST_ERR] = errFlags_r != `TF_RST;            // [R18]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      rdData_r <= '0;
    else
    begin
      unique case (hostAddr)
        `TF_DATA:  rdData_r <= '0;
        `TF_FEAT:  rdData_r <= {8'h00, errFlags_r};
        `TF_COUNT: rdData_r <= {8'h00, count_r};
        `TF_SECT:  rdData_r <= {8'h00, sec_r};
        `TF_CYLLO: rdData_r <= {8'h00, cylLo_r};
        `TF_CYLHI: rdData_r <= {8'h00, cylHi_r};
        `TF_DEVHD: rdData_r <= {8'h00, devHead_r};
        `TF_CMD:   rdData_r <= {8'h00, status};
      endcase
    end
  end

  assign hostRdData    = rdData_r;
  assign retryDisable  = retryDisable_r;
  assign featureFlags  = flags_r;
  assign spinUpReq     = spinUp_r;
  assign otherCmdValid = otherCmd_r;
  assign otherCmdCode  = otherCode_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  zero_count_a: assert property (startWrite && count_r == `TF_RST // [R2]
    |=> sectorsLeft_r == 9'h100 && wordsLeft_r == 17'h1_0000)
    else $error("zero count not taken as 256 sectors");
  retry_bit_a: assert property (startWrite // [R1]
    |=> retryDisable_r == ($past(hostWrData[0]) && !flags_r[`FL_WCACHE]
                           && $past(hostWrData[7:1]) == 7'h18))
    else $error("retry disable mismatch");
  cache_ignore_a: assert property (flags_r[`FL_WCACHE] && startWrite // [R8]
    |=> !retryDisable_r)
    else $error("retry bit honoured with cache on");
  stop_fail_a: assert property (failEvt // [R4]
    |=> state_r == ST_IDLE && !hostDrq && count_r == $past(sectorsLeft_r[7:0]))
    else $error("write continued past failing sector");
  remain_zero_a: assert property (sectEvt && lastSect // [R6]
    |=> count_r == `TF_RST && state_r == ST_IDLE && !status[`ST_BSY])
    else $error("count not zero at clean end");
  addr_step_a: assert property (sectEvt && !lastSect && lbaMode // [R7]
    |=> curAddr == $past(curAddr) + 28'h000_0001)
    else $error("LBA not advanced after sector");
  reject_abort_a: assert property (cmdWr && cmdClass == CMD_REJECT // [R18]
    |=> errFlags_r[`ERR_ABT] && status[`ST_ERR] && state_r == ST_IDLE)
    else $error("unsupported opcode not aborted");
  err_bits_a: assert property ((errFlags_r & 8'heb) == 8'h00) // [R19]
    else $error("error bit other than ID_NOT_FOUND_FLAG or ABORTED_COMMAND_FLAG set");
  verify_write_a: assert property (cmdWr && hostWrData[7:0] == `OP_WRITE_VERIFY // [R10]
    |=> xfer && hostDrq)
    else $error("write verify did not start a write");
  apm_set_a: assert property (startFeat && feat_r == `FT_APM_ON // [R11]
    |=> flags_r[`FL_APM] ##1 flags_r[`FL_APM] || $past(startFeat))
    else $error("APM enable not applied");
  drq_words_a: assert property (xfer && wordsLeft_r == '0 |-> !hostDrq && !push) // [R3]
    else $error("data accepted beyond requested words");

  clean_end_c: cover property (sectEvt && lastSect);
  fail_end_c:  cover property (failEvt && sectorsLeft_r > 9'h001);
  feat_ok_c:   cover property (startFeat && featOk);
  fifo_full_c: cover property (drq && !fifoInReady);
endmodule : ata_sector_write_cmd_decode

// *** ata_host_model.sv ***
// Host adapter model: task-file accesses and data-word pushes
`timescale 1ns/1ns
module ata_host_model (
  input  wire logic        core_clk,
  input  wire logic        hostDrq,
  input  wire logic        hostWrReady,
  input  wire logic [15:0] hostRdData,
  output logic             hostWrEn,
  output logic      [2:0]  hostAddr,
  output logic      [15:0] hostWrData
);
  logic [15:0] sentCnt = 16'h0000;
  initial {hostWrEn, hostAddr, hostWrData} = '0;

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(negedge core_clk);
    hostWrEn = 1'b1;
    hostAddr = a;
    hostWrData = d;
    @(negedge core_clk);
    hostWrEn = 1'b0;
    hostWrData = ~d;
  endtask : wr

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(negedge core_clk);
    hostAddr = a;
    @(negedge core_clk);
    d = hostRdData;
  endtask : rd

  // Words only offered while the device has room; refused words never count
  task automatic push(input int limit);
    for (int i = 0; i < limit; i++)
    begin
      @(negedge core_clk);
      hostWrEn = hostWrReady;
      hostAddr = 3'h0;
      hostWrData = hostWrReady ? sentCnt ^ 16'h5a5a : ~hostWrData;
      if (!hostDrq)
        break;
      if (hostWrReady)
        sentCnt++;
    end
  endtask : push
endmodule : ata_host_model

// *** ata_sector_write_cmd_decode_bench.sv ***
// Self-checking bench for the sector-write command decoder
`timescale 1ns/1ns
`include "ata_wr_map.svh"
module ata_sector_write_cmd_decode_bench;
  import ata_wr_pkg::*;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        hostWrEn, hostDrq, hostWrReady, mediaValid, retryDisable;
  logic        mediaReady = 1'b0;
  logic        mediaSectorDone = 1'b0;
  logic        mediaUncErr = 1'b0;
  logic        mediaIdnf = 1'b0;
  logic        spinUpReq, otherCmdValid, pend = 1'b0, errKind = 1'b0;
  logic [2:0]  hostAddr;
  logic [15:0] hostWrData, hostRdData, mediaData, rcvCnt = 16'h0000;
  byte_t       featureFlags, otherCmdCode;
  int          fails = 0, checks = 0, cyc = 0, wordCnt = 0, secCnt = 0, errSect = 999;

  ata_sector_write_cmd_decode dut (.core_clk(core_clk), .reset(reset), .hostWrEn(hostWrEn),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData), .hostDrq(hostDrq),
    .hostWrReady(hostWrReady), .mediaValid(mediaValid), .mediaReady(mediaReady),
    .mediaData(mediaData), .mediaSectorDone(mediaSectorDone), .mediaUncErr(mediaUncErr),
    .mediaIdnf(mediaIdnf), .retryDisable(retryDisable), .featureFlags(featureFlags),
    .spinUpReq(spinUpReq), .otherCmdValid(otherCmdValid), .otherCmdCode(otherCmdCode));
  ata_host_model host (.core_clk(core_clk), .hostDrq(hostDrq), .hostWrReady(hostWrReady),
    .hostRdData(hostRdData), .hostWrEn(hostWrEn), .hostAddr(hostAddr),
    .hostWrData(hostWrData));

  initial forever #5 core_clk = ~core_clk;

  // Media drain with long stalls so the FIFO fills and refuses the host
  always @(negedge core_clk)
  begin
    mediaSectorDone = pend && secCnt != errSect;
    mediaUncErr = pend && secCnt == errSect && !errKind;
    mediaIdnf = pend && secCnt == errSect && errKind;
    if (pend)
      secCnt++;
    pend = 1'b0;
    mediaReady = !cyc[6];
    if (mediaReady && mediaValid)
    begin
      chk("media word", rcvCnt ^ 16'h5a5a, mediaData);
      rcvCnt++;
      wordCnt++;
      pend = wordCnt % 256 == 0;
    end
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chk_reg(input string n, input logic [2:0] a, input logic [15:0] e,
                         input logic [15:0] m = 16'hffff);
    logic [15:0] v;
    host.rd(a, v);
    chk(n, e, v & m);
  endtask : chk_reg

  task automatic run_write(input byte_t op, cnt, sn, cl, ch, dh, input int es,
                           input logic ek);
    logic [15:0] v;
    errSect = es;
    errKind = ek;
    secCnt = 0;
    wordCnt = 0;
    rcvCnt = host.sentCnt;
    host.wr(`TF_COUNT, {8'h00, cnt});
    host.wr(`TF_SECT, {8'h00, sn});
    host.wr(`TF_CYLLO, {8'h00, cl});
    host.wr(`TF_CYLHI, {8'h00, ch});
    host.wr(`TF_DEVHD, {8'h00, dh});
    host.wr(`TF_CMD, {8'h00, op});
    host.push(6000);
    for (int i = 0; i < 400; i++)
    begin
      host.rd(`TF_CMD, v);
      if (!v[7] && !hostDrq)
        break;
    end
    // A write that never leaves busy shows up here as a mismatch
    chk("busy end", 16'h0000, {15'h0000, v[7]});
  endtask : run_write

  task automatic test_reset();
    chk_reg("status", `TF_CMD, 16'h0050);
    chk_reg("error", `TF_FEAT, 16'h0000);
    chk_reg("count", `TF_COUNT, 16'h0000);
  endtask : test_reset

  task automatic test_features();
    byte_t codes [16] = '{8'h05, 8'h85, 8'h42, 8'hc2, 8'h44, 8'hbb, 8'h55, 8'haa,
                          8'h66, 8'hcc, 8'h06, 8'h86, 8'h09, 8'h89, 8'h02, 8'h82};
    byte_t exp;
    exp = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      exp[i / 2] = ~i[0];
      host.wr(`TF_FEAT, {8'h00, codes[i]});
      host.wr(`TF_CMD, {8'h00, `OP_SET_FEATURES});
      chk("feature flags", {8'h00, exp}, {8'h00, featureFlags});
    end
    host.wr(`TF_FEAT, 16'h0007);
    host.wr(`TF_CMD, {8'h00, `OP_SET_FEATURES});
    chk("spin up", 16'h0001, {15'h0000, spinUpReq});
    chk_reg("error", `TF_FEAT, 16'h0000);
    host.wr(`TF_FEAT, 16'h005e);
    host.wr(`TF_CMD, {8'h00, `OP_SET_FEATURES});
    chk("feature flags", 16'h0000, {8'h00, featureFlags});
    chk_reg("error", `TF_FEAT, 16'h0004);
    chk_reg("status", `TF_CMD, 16'h0051);
  endtask : test_features

  task automatic test_opcodes();
    byte_t ops [5] = '{8'hc7, 8'hcc, 8'hf1, 8'h03, 8'h92};
    for (int i = 0; i < 5; i++)
    begin
      host.wr(`TF_CMD, {8'h00, ops[i]});
      chk("other valid", {15'h0000, i < 3}, {15'h0000, otherCmdValid});
      if (i < 3)
        chk("other code", {8'h00, ops[i]}, {8'h00, otherCmdCode});
      chk_reg("error", `TF_FEAT, i < 3 ? 16'h0000 : 16'h0004);
    end
  endtask : test_opcodes

  task automatic test_lba_abort();
    run_write(8'h31, 8'h00, 8'hfe, 8'h34, 8'h12, 8'h4a, 2, 1'b0);
    chk("retry off", 16'h0001, {15'h0000, retryDisable});
    chk("media left", 16'h0000, {15'h0000, mediaValid});
    chk_reg("count", `TF_COUNT, 16'h00fe);
    chk_reg("lba low", `TF_SECT, 16'h0000);
    chk_reg("lba mid", `TF_CYLLO, 16'h0035);
    chk_reg("lba high", `TF_CYLHI, 16'h0012);
    chk_reg("lba top", `TF_DEVHD, 16'h000a, 16'h000f);
    chk_reg("error", `TF_FEAT, 16'h0004);
    chk_reg("status", `TF_CMD, 16'h0051);
  endtask : test_lba_abort

  task automatic test_cached_ok();
    host.wr(`TF_FEAT, {8'h00, `FT_WCACHE_ON});
    host.wr(`TF_CMD, {8'h00, `OP_SET_FEATURES});
    run_write(8'h31, 8'h01, 8'h05, 8'h07, 8'h00, 8'ha3, 999, 1'b0);
    chk("retry off", 16'h0000, {15'h0000, retryDisable});
    chk("words", 16'h0100, wordCnt[15:0]);
    chk_reg("count", `TF_COUNT, 16'h0000);
    chk_reg("sector", `TF_SECT, 16'h0005);
    chk_reg("cyl low", `TF_CYLLO, 16'h0007);
    chk_reg("head", `TF_DEVHD, 16'h0003, 16'h000f);
    chk_reg("error", `TF_FEAT, 16'h0000);
    chk_reg("status", `TF_CMD, 16'h0050);
    host.wr(`TF_FEAT, {8'h00, `FT_WCACHE_OFF});
    host.wr(`TF_CMD, {8'h00, `OP_SET_FEATURES});
  endtask : test_cached_ok

  task automatic test_verify_idnf();
    // Retry bit clear: retries stay on; failure on the very first sector
    run_write(`OP_WRITE_RETRY, 8'h01, 8'h10, 8'h20, 8'h00, 8'hc0, 0, 1'b0);
    chk("retry off", 16'h0000, {15'h0000, retryDisable});
    chk_reg("count", `TF_COUNT, 16'h0001);
    chk_reg("lba low", `TF_SECT, 16'h0010);
    chk_reg("error", `TF_FEAT, 16'h0004);
    run_write(`OP_WRITE_VERIFY, 8'h02, 8'h3f, 8'h02, 8'h01, 8'haf, 1, 1'b1);
    chk("retry off", 16'h0000, {15'h0000, retryDisable});
    chk_reg("count", `TF_COUNT, 16'h0001);
    chk_reg("sector", `TF_SECT, 16'h0001);
    chk_reg("cyl low", `TF_CYLLO, 16'h0003);
    chk_reg("cyl high", `TF_CYLHI, 16'h0001);
    chk_reg("head", `TF_DEVHD, 16'h0000, 16'h000f);
    chk_reg("error", `TF_FEAT, 16'h0010);
    chk_reg("status", `TF_CMD, 16'h0051);
  endtask : test_verify_idnf

  initial
  begin
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    test_reset();
    test_features();
    test_opcodes();
    test_lba_abort();
    test_cached_ok();
    test_verify_idnf();
    print_verdict();
  end
endmodule : ata_sector_write_cmd_decode_bench
